// ==== core/tpo_buf2.sv ====
// two-entry valid/ready buffer in the trace word path
// assumes one clock and an active-high asynchronous reset
`timescale 1ns/1ps
module tpo_buf2 #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_q [2];
	logic rd_q;
	logic wr_q;
	logic [1:0] cnt_q;
	logic push;
	logic pop;
	if (WIDTH < 1) begin : g_bad_width
		$error("width must be positive");
	end
	assign in_ready = (cnt_q != 2'h2); // see [RQ20]
	assign out_valid = (cnt_q != 2'h0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
		end else if (push) begin
			mem_q[wr_q] <= in_data; // see [RQ18]
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// ==== core/tpo_pkg.sv ====
// constants, types and the rule summary for the trace port output unit
// assumes a single clock domain; all control bits arrive as plain ports
// What this block does
// [RQ1] port widths two to thirty-two bits supported
// [RQ2] port clock always exported with data
// [RQ3] control pin always driven every cycle
// [RQ4] ctl 0 data, 1+10 trigger, 1+bit0 idle
// [RQ5] analyzer samples on both clock edges
// [RQ6] current width register sets valid bits
// [RQ7] words forwarded unmodified, pass-through only
// [RQ8] integrator ties max size to pins minus one
// [RQ9] supported widths reflect tied max size
// [RQ10] triggers only from enabled flush or input
// [RQ11] trigger raises flush before trigger shown
// [RQ12] flush by manual bit or trigger event
// [RQ13] flush status high while flush runs
// [RQ14] two flushes; trigger flush wins ties
// [RQ15] stop appends aa/55, 01 word, zeros
// [RQ16] port clock is bus clock halved
// [RQ17] divider is plain positive-edge register
// [RQ18] buffer holds words until serializer ready
// [RQ19] no authentication input disables unit
// [RQ20] input stalls while buffer cannot accept
// [RQ21] trigger taken on rising edge only
// [RQ22] flush status mirrors flush request line
// [RQ23] words sliced lsb first, one per edge
package tpo_pkg;
	localparam int unsigned DATA_W = 32;
	localparam logic [31:0] CPR_RESET = 32'h0000_0002;
	localparam logic [31:0] SUPPORTED_FULL = 32'h8000_808A;
	localparam logic [31:0] EOT_ALT_WORD = 32'hAA55_AA55;
	localparam logic [31:0] EOT_MARK_WORD = 32'h0155_AA55;
	localparam logic [31:0] EOT_ZERO_WORD = 32'h0000_0000;
	localparam logic [1:0] EOT_ZERO_COUNT = 2'h2;
	localparam logic [31:0] IDLE_PATTERN = 32'h0000_0001;
	localparam logic [31:0] TRIG_PATTERN = 32'h0000_0002;
	typedef enum logic [2:0] {
		TPO_RUN = 3'b000,
		TPO_EOT_ALT = 3'b001,
		TPO_EOT_MARK = 3'b010,
		TPO_EOT_ZERO = 3'b011,
		TPO_STOPPED = 3'b100
	} tpo_state_t;
endpackage

// ==== core/tpo_top.sv ====
// trace port output unit: input stream, buffer, serializer, triggers, flush, stop
// assumes the trace source answers flush requests with flush_ack; one clock
`timescale 1ns/1ps
module tpo_top (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic atb_valid,
	output logic atb_ready,
	input wire logic [tpo_pkg::DATA_W-1:0] atb_data,
	output logic flush_req,
	input wire logic flush_ack,
	input wire logic trigger_input,
	input wire logic [4:0] max_pin_count_tieoff,
	input wire logic [31:0] current_width_register,
	output logic [31:0] supported_widths,
	input wire logic manual_flush_set,
	output logic manual_flush_busy,
	input wire logic flush_on_trigger_enable,
	input wire logic trig_on_input_enable,
	input wire logic trig_on_flush_enable,
	input wire logic stop_on_flush_enable,
	input wire logic stop_manual,
	input wire logic start_trace,
	output logic flush_pending_flag,
	output logic stopped,
	output logic port_sample_clock,
	output logic port_control_pin,
	output logic [tpo_pkg::DATA_W-1:0] port_data_bus
);
	import tpo_pkg::*;
	// no authentication input exists on this unit; see [RQ19]
	logic buf_valid;
	logic buf_ready;
	logic [DATA_W-1:0] buf_data;
	logic [5:0] slice_bits;
	logic clk_div_q;
	logic trig_in_q;
	logic trig_edge;
	logic man_pend_q;
	logic trg_pend_q;
	logic flush_act_q;
	logic flush_is_trg_q;
	logic trig_pend_q;
	logic stop_req_q;
	logic flush_done;
	tpo_state_t state_q;
	logic [1:0] zero_cnt_q;
	logic [DATA_W-1:0] sh_q;
	logic [5:0] left_q;
	logic word_need;
	logic [DATA_W-1:0] next_word;
	logic next_have;
	logic [DATA_W-1:0] slice_mask;
	logic run_open;
	// input closes once a stop is asked for, so no word is trapped behind the end pattern
	assign run_open = (state_q == TPO_RUN) && !stop_req_q;
	tpo_buf2 #(.WIDTH(DATA_W)) u_buf (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(atb_valid && run_open),
		.in_ready(buf_ready),
		.in_data(atb_data),
		.out_valid(buf_valid),
		.out_ready(word_need && state_q == TPO_RUN),
		.out_data(buf_data)
	);
	assign atb_ready = buf_ready && run_open; // see [RQ20]
	tpo_width u_width (
		.max_pin_count_tieoff(max_pin_count_tieoff),
		.current_width_register(current_width_register),
		.supported_widths(supported_widths),
		.slice_bits(slice_bits)
	);
	// port clock: plain divide-by-two flop beside the data flops
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) clk_div_q <= 1'b0;
		else clk_div_q <= ~clk_div_q; // see [RQ16] see [RQ17]
	end
	assign port_sample_clock = clk_div_q; // see [RQ2]
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) trig_in_q <= 1'b0;
		else trig_in_q <= trigger_input;
	end
	assign trig_edge = trigger_input && !trig_in_q; // see [RQ21]
	assign flush_done = flush_act_q && flush_ack;
	// flush requests: trigger-event flush served first, manual one after
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			man_pend_q <= 1'b0;
			trg_pend_q <= 1'b0;
			flush_act_q <= 1'b0;
			flush_is_trg_q <= 1'b0;
		end else begin
			if (flush_done) begin
				if (flush_is_trg_q) trg_pend_q <= 1'b0;
				else man_pend_q <= 1'b0;
				flush_act_q <= 1'b0;
			end else if (!flush_act_q && (trg_pend_q || man_pend_q)) begin
				flush_act_q <= 1'b1;
				flush_is_trg_q <= trg_pend_q; // see [RQ14]
			end
			if (manual_flush_set) man_pend_q <= 1'b1; // see [RQ12]
			if (trig_edge && flush_on_trigger_enable) trg_pend_q <= 1'b1; // see [RQ11]
		end
	end
	assign flush_req = flush_act_q;
	assign flush_pending_flag = flush_act_q; // see [RQ13] see [RQ22]
	assign manual_flush_busy = man_pend_q;
	// trigger indication pending until emitted as a port cycle
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) trig_pend_q <= 1'b0;
		else if ((trig_edge && trig_on_input_enable) ||
			(flush_done && trig_on_flush_enable)) trig_pend_q <= 1'b1; // see [RQ10]
		else if (left_q == 6'h00 && !next_have) trig_pend_q <= 1'b0;
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) stop_req_q <= 1'b0;
		else if (stop_manual || (flush_done && stop_on_flush_enable)) stop_req_q <= 1'b1;
		else if (state_q == TPO_EOT_ALT) stop_req_q <= 1'b0;
	end
	assign word_need = (left_q == 6'h00) || (left_q <= slice_bits);
	// source of the next word: buffer while running, end pattern while stopping
	always_comb begin
		next_word = buf_data; // see [RQ7]
		next_have = buf_valid && state_q == TPO_RUN;
		case (state_q)
			TPO_EOT_ALT: begin
				next_word = EOT_ALT_WORD;
				next_have = 1'b1;
			end
			TPO_EOT_MARK: begin
				next_word = EOT_MARK_WORD;
				next_have = 1'b1;
			end
			TPO_EOT_ZERO: begin
				next_word = EOT_ZERO_WORD;
				next_have = 1'b1;
			end
			default: begin
			end
		endcase
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= TPO_STOPPED;
			zero_cnt_q <= 2'h0;
		end else begin
			case (state_q)
				TPO_RUN: begin
					if (stop_req_q && !buf_valid && left_q <= slice_bits)
						state_q <= TPO_EOT_ALT; // see [RQ15]
				end
				TPO_EOT_ALT: if (word_need) state_q <= TPO_EOT_MARK;
				TPO_EOT_MARK: begin
					if (word_need) begin
						state_q <= TPO_EOT_ZERO;
						zero_cnt_q <= 2'h0;
					end
				end
				TPO_EOT_ZERO: begin
					if (word_need) begin
						zero_cnt_q <= zero_cnt_q + 2'h1;
						if (zero_cnt_q + 2'h1 == EOT_ZERO_COUNT) state_q <= TPO_STOPPED;
					end
				end
				TPO_STOPPED: if (start_trace) state_q <= TPO_RUN;
				default: state_q <= TPO_STOPPED;
			endcase
		end
	end
	assign stopped = (state_q == TPO_STOPPED);
	for (genvar b = 0; b < DATA_W; b++) begin : g_mask
		assign slice_mask[b] = (b < int'(slice_bits));
	end
	// serializer: one slice per port clock edge, low slice first
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sh_q <= '0;
			left_q <= 6'h00;
			port_control_pin <= 1'b1;
			port_data_bus <= IDLE_PATTERN;
		end else if (left_q != 6'h00) begin
			port_control_pin <= 1'b0; // see [RQ4]
			port_data_bus <= sh_q & slice_mask; // see [RQ23]
			sh_q <= sh_q >> slice_bits;
			left_q <= (left_q > slice_bits) ? left_q - slice_bits : 6'h00;
			if (left_q <= slice_bits && next_have) begin
				sh_q <= next_word;
				left_q <= 6'(DATA_W);
			end
		end else if (next_have) begin
			port_control_pin <= 1'b0;
			port_data_bus <= next_word & slice_mask; // see [RQ1]
			sh_q <= next_word >> slice_bits;
			left_q <= 6'(DATA_W) - slice_bits;
		end else if (trig_pend_q) begin
			port_control_pin <= 1'b1;
			port_data_bus <= TRIG_PATTERN;
		end else begin
			port_control_pin <= 1'b1; // see [RQ3]
			port_data_bus <= IDLE_PATTERN;
		end
	end
endmodule

// ==== core/tpo_width.sv ====
// turns the tied pin count into the supported widths mask and the current width into a slice width
// assumes current width holds one supported bit
`timescale 1ns/1ps
module tpo_width (
	input wire logic [4:0] max_pin_count_tieoff,
	input wire logic [31:0] current_width_register,
	output logic [31:0] supported_widths,
	output logic [5:0] slice_bits
);
	import tpo_pkg::*;
	logic [5:0] pins;
	assign pins = {1'b0, max_pin_count_tieoff} + 6'h01;
	for (genvar b = 0; b < 32; b++) begin : g_sup
		assign supported_widths[b] = SUPPORTED_FULL[b] && (b < int'(pins)); // see [RQ9]
	end
	always_comb begin
		slice_bits = 6'h02; // see [RQ6]
		for (int i = 0; i < 32; i++) begin
			if (current_width_register[i]) slice_bits = 6'(i + 1);
		end
	end
endmodule

// ==== tb/tpo_capture_model.sv ====
// capture analyzer model on the trace port
// assumes width is the current slice width in bits
`timescale 1ns/1ps
module tpo_capture_model (
	input wire logic port_sample_clock,
	input wire logic port_control_pin,
	input wire logic [31:0] port_data_bus,
	input wire logic [5:0] width,
	output int trig_count = 0
);
	logic [31:0] cap_q[$];
	// pad delay puts the sample inside stable data
	always @(port_sample_clock) begin
		#1;
		if (port_control_pin === 1'b0) begin
			cap_q.push_back(port_data_bus & (32'hFFFF_FFFF >> (32 - width)));
		end else if (port_data_bus[1:0] === 2'b10) begin
			trig_count++;
		end
	end
endmodule

// ==== tb/tpo_top_monitor.sv ====
// port checker of the trace port output unit
// bound to tpo_top; one clock, reset high
`timescale 1ns/1ps
module tpo_top_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic atb_ready,
	input wire logic flush_req,
	input wire logic flush_ack,
	input wire logic manual_flush_set,
	input wire logic manual_flush_busy,
	input wire logic flush_pending_flag,
	input wire logic stopped,
	input wire logic port_sample_clock,
	input wire logic port_control_pin,
	input wire logic [tpo_pkg::DATA_W-1:0] port_data_bus
);
	import tpo_pkg::*;
	logic trg;
	assign trg = port_control_pin && port_data_bus == TRIG_PATTERN;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	clk_div_a: assert property (!$past(reset) |->
		port_sample_clock != $past(port_sample_clock)) else $error("clock stuck");
	flag_mirror_a: assert property (flush_pending_flag == flush_req)
		else $error("flag differs");
	stop_refuse_a: assert property (stopped |-> !atb_ready)
		else $error("ready when stopped");
	ctl_code_a: assert property (port_control_pin |-> trg || port_data_bus == 32'h1)
		else $error("bad control code");
	trig_once_a: assert property (trg |=> !trg)
		else $error("trigger repeated");
	flush_hold_a: assert property (flush_req && !flush_ack |=> flush_req)
		else $error("flush dropped");
	flush_end_a: assert property (flush_req && flush_ack |=> !flush_req)
		else $error("flush kept");
	busy_set_a: assert property (manual_flush_set |=> manual_flush_busy)
		else $error("busy not set");
	cover property (trg);
	cover property ($fell(flush_req));
	cover property ($rose(stopped));
endmodule
bind tpo_top tpo_top_monitor tpo_top_monitor_inst (.ref_clk, .reset, .atb_ready, .flush_req,
	.flush_ack, .manual_flush_set, .manual_flush_busy, .flush_pending_flag, .stopped,
	.port_sample_clock, .port_control_pin, .port_data_bus);

// ==== tb/tpo_top_tb.sv ====
// bench: trace source, flush source and control bits of the port unit
// a capture model reads the port; ack comes a few cycles after a request
`timescale 1ns/1ps
module tpo_top_tb;
	logic ref_clk, reset, atb_valid, atb_ready, flush_req, trigger_input;
	logic flush_ack = 1'b0;
	logic fr_d = 1'b0;
	logic manual_flush_set, manual_flush_busy, flush_on_trigger_enable, trig_on_input_enable;
	logic trig_on_flush_enable, stop_on_flush_enable, stop_manual, start_trace, stopped;
	logic flush_pending_flag, port_sample_clock, port_control_pin;
	logic [31:0] atb_data, current_width_register, supported_widths, port_data_bus, d, m;
	logic [31:0] eot[4] = '{32'hAA55_AA55, 32'h0155_AA55, 32'h0, 32'h0};
	logic [4:0] max_pin_count_tieoff;
	logic [5:0] cw;
	int bad_count, checks_done, stalls, flushes, age, trig_count, i;
	int wl[3] = '{2, 8, 32};
	tpo_top tpo_top_inst (.ref_clk, .reset, .atb_valid, .atb_ready, .atb_data, .flush_req,
		.flush_ack, .trigger_input, .max_pin_count_tieoff, .current_width_register,
		.supported_widths, .manual_flush_set, .manual_flush_busy, .flush_on_trigger_enable,
		.trig_on_input_enable, .trig_on_flush_enable, .stop_on_flush_enable, .stop_manual,
		.start_trace, .flush_pending_flag, .stopped, .port_sample_clock, .port_control_pin,
		.port_data_bus);
	tpo_capture_model tpo_capture_model_inst (.port_sample_clock, .port_control_pin,
		.port_data_bus, .width(cw), .trig_count);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		flushes += flush_req && !fr_d;
		fr_d = flush_req;
		#1;
		age = flush_req ? age + 1 : 0;
		flush_ack = age > 3;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic wt();
		if (i >= 99) begin
			bad_count++;
			final_report();
		end
	endtask
	task automatic send(input logic [31:0] w);
		atb_data = w;
		atb_valid = 1'b1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
			stalls += !atb_ready;
		end while (!atb_ready && i < 99);
		wt();
		#1;
	endtask
	initial begin
		{atb_valid, trigger_input, manual_flush_set, stop_manual} = '0;
		{flush_on_trigger_enable, trig_on_input_enable, trig_on_flush_enable} = '0;
		{stop_on_flush_enable, start_trace, atb_data, cw} = '0;
		reset = 1'b1;
		max_pin_count_tieoff = 5'h1F;
		current_width_register = 32'h2;
		step(10);
		reset = 1'b0;
		start_trace = 1'b1;
		check({stopped, port_control_pin, flush_req, port_data_bus[0]}, 4'hD);
		check(supported_widths, 32'h8000_808A);
		max_pin_count_tieoff = 5'h07;
		#1 check(supported_widths, 32'h8A);
		max_pin_count_tieoff = 5'h1F;
		step(1);
		start_trace = 1'b0;
		foreach (wl[k]) begin
			cw = 6'(wl[k]);
			m = 32'hFFFF_FFFF >> (32 - wl[k]);
			current_width_register = 32'h1 << (wl[k] - 1);
			step(4);
			tpo_capture_model_inst.cap_q.delete();
			stalls = 0;
			for (int j = 0; j < 5; j++) send(32'h8C3A_61F5 + j * 32'h0111_1111);
			atb_valid = 1'b0;
			for (i = 0; i < 99 && tpo_capture_model_inst.cap_q.size() < 160 / wl[k]; i++) step(1);
			wt();
			for (int j = 0; j < 160 / wl[k]; j++) begin
				d = 32'h8C3A_61F5 + (j * wl[k] / 32) * 32'h0111_1111;
				check(tpo_capture_model_inst.cap_q[j], d >> (j * wl[k] % 32) & m);
			end
			if (wl[k] == 2) check(stalls > 0, 1'b1);
		end
		for (int e = 0; e < 2; e++) begin
			trig_on_input_enable = e[0];
			trigger_input = 1'b1;
			step(5);
			trigger_input = 1'b0;
			step(10);
			check(trig_count, e);
		end
		{trig_on_input_enable, trig_on_flush_enable, manual_flush_set} = 3'b011;
		step(1);
		manual_flush_set = 1'b0;
		step(1);
		check(manual_flush_busy, 1'b1);
		for (i = 0; i < 99 && manual_flush_busy; i++) step(1);
		wt();
		step(10);
		check(flushes, 1);
		check(trig_count, 2);
		{flush_on_trigger_enable, manual_flush_set, trigger_input} = 3'b111;
		step(1);
		manual_flush_set = 1'b0;
		for (i = 0; i < 99 && (manual_flush_busy || flush_req); i++) step(1);
		wt();
		step(10);
		check(flushes, 3);
		check(trig_count, 4);
		{trigger_input, flush_on_trigger_enable, trig_on_flush_enable} = 3'b000;
		current_width_register = 32'h8000_0000;
		cw = 6'h20;
		step(4);
		// first stop by the manual bit, second by a completed flush after a reset while stopped
		for (int s = 0; s < 2; s++) begin
			tpo_capture_model_inst.cap_q.delete();
			{stop_on_flush_enable, manual_flush_set, stop_manual} = {s[0], s[0], !s[0]};
			step(1);
			{manual_flush_set, stop_manual, start_trace} = 3'b000;
			for (i = 0; i < 99 && !stopped; i++) step(1);
			wt();
			step(2);
			foreach (eot[k]) check(tpo_capture_model_inst.cap_q[k], eot[k]);
			reset = 1'b1;
			step(2);
			reset = 1'b0;
			check({stopped, port_control_pin, flush_req, atb_ready}, 4'hC);
			start_trace = 1'b1;
		end
		check(flushes, 4);
		final_report();
	end
endmodule
